/* hw/urxcs_pkg.sv */
// Constants, field layouts and types for the serial receiver with clock select.
// Assumes one system clock; every address below is a full byte address on the register port.
package urxcs_pkg;

    // ****************************************
    // Register addresses, channel 0 and channel 1
    // ****************************************
    localparam logic [31:0] URXCS_MODE_ADDR0 = 32'hFFFFFA00;    // Serial mode control
    localparam logic [31:0] URXCS_BUF_ADDR0 = 32'hFFFFFA02;     // Receive buffer
    localparam logic [31:0] URXCS_STAT_ADDR0 = 32'hFFFFFA03;    // Receive error status
    localparam logic [31:0] URXCS_CLKSEL_ADDR0 = 32'hFFFFFA06;  // Basic clock select
    localparam logic [31:0] URXCS_DIV_ADDR0 = 32'hFFFFFA07;     // Divisor register
    localparam logic [31:0] URXCS_MODE_ADDR1 = 32'hFFFFFA10;
    localparam logic [31:0] URXCS_BUF_ADDR1 = 32'hFFFFFA12;
    localparam logic [31:0] URXCS_STAT_ADDR1 = 32'hFFFFFA13;
    localparam logic [31:0] URXCS_CLKSEL_ADDR1 = 32'hFFFFFA16;
    localparam logic [31:0] URXCS_DIV_ADDR1 = 32'hFFFFFA17;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [7:0] URXCS_MODE_RST = 8'h00;
    localparam logic [7:0] URXCS_BUF_RST = 8'h00;
    localparam logic [7:0] URXCS_CLKSEL_RST = 8'h00;
    localparam logic [7:0] URXCS_DIV_RST = 8'hFF;

    // ****************************************
    // Counts and limits
    // ****************************************
    localparam logic [3:0] URXCS_CLKSEL_MAX = 4'hB;      // Codes above are prohibited
    localparam int URXCS_PRE_W = 11;                     // Prescaler width, divides up to 2^11
    localparam logic [2:0] URXCS_LAST_BIT = 3'h7;        // Eight data bits per frame

    // ****************************************
    // Field layouts
    // ****************************************
    typedef enum logic [1:0] {
        URXCS_PAR_NONE = 2'b00,
        URXCS_PAR_ZERO = 2'b01,
        URXCS_PAR_ODD = 2'b10,
        URXCS_PAR_EVEN = 2'b11
    } urxcs_parity_t;

    typedef struct packed {
        logic unit_enable;              // Bit 7
        logic tx_enable;                // Bit 6
        logic receive_enable;           // Bit 5
        urxcs_parity_t parity_mode;     // Bits 4:3
        logic [1:0] spare;              // Bits 2:1, read back as written
        logic error_irq_routing;        // Bit 0
    } urxcs_mode_t;

    typedef struct packed {
        logic [4:0] spare;              // Bits 7:3, read as zero
        logic parity_error_flag;        // Bit 2
        logic framing_error_flag;       // Bit 1
        logic overrun_flag;             // Bit 0
    } urxcs_status_t;

    typedef enum logic [2:0] {
        URXCS_IDLE = 3'b000,
        URXCS_START = 3'b001,
        URXCS_DATA = 3'b010,
        URXCS_PARITY = 3'b011,
        URXCS_STOP = 3'b100
    } urxcs_state_t;

endpackage

/* hw/urxcs_channel.sv */
// One channel of the serial receiver: clock select, rate dividers, noise filter,
// frame receiver, error status and interrupt pulses.
// Assumes all inputs except the asynchronous nrst are synchronous to clk; the second channel is a second instance.
// What this block does
// - Stop bit copies frame, pulses complete
// - Overrun keeps buffer, routed interrupt pulses
// - Parity/framing error still stores frame
// - Disabling reception aborts frame silently
// - No complete interrupt while reception off
// - Error sets flag, routing picks interrupt
// - Reading error status clears all flags
// - Missing stop bit sets framing flag
// - Unread buffer at frame end sets overrun
// - Even parity generate and check
// - Odd parity generate and check
// - Zero parity sends zero, never checks
// - No parity position, no parity error
// - Filter needs two equal basic-clock samples
// - Filter delay at most two basic clocks
// - Separate transmit and receive divider counters
// - Basic clock held low unless unit enabled
// - Basic clock is system clock over 2^code
// - Divider counts basic clock by divisor
// - Start bit begins frame only when enabled
// - Bit rate is basic clock over 2k
`timescale 1ns/1ps
`default_nettype none

module urxcs_channel #(
    parameter bit CHANNEL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial line and transmit helpers
    input wire logic serial_receive_line,
    input wire logic [7:0] tx_data,
    output logic tx_parity_bit,
    output logic tx_half_tick,
    // Interrupt pulses
    output logic receive_complete_irq,
    output logic receive_error_irq
);
    import urxcs_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_reg;   // Two-stage release of nrst
    logic rst_n;                // Synchronously released reset for the rest

    // Asynchronous assertion, release after two edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ****************************************
    // Address decode and software registers
    // ****************************************
    logic [31:0] a_mode, a_buf, a_stat, a_clk, a_div;
    assign a_mode = CHANNEL ? URXCS_MODE_ADDR1 : URXCS_MODE_ADDR0;
    assign a_buf = CHANNEL ? URXCS_BUF_ADDR1 : URXCS_BUF_ADDR0;
    assign a_stat = CHANNEL ? URXCS_STAT_ADDR1 : URXCS_STAT_ADDR0;
    assign a_clk = CHANNEL ? URXCS_CLKSEL_ADDR1 : URXCS_CLKSEL_ADDR0;
    assign a_div = CHANNEL ? URXCS_DIV_ADDR1 : URXCS_DIV_ADDR0;
    urxcs_mode_t mode_reg, mode_next;           // Serial mode control
    logic [3:0] clksel_reg, clksel_next;        // Clock select field
    logic [7:0] div_reg, div_next;              // Divisor value
    logic [7:0] rdata_reg, rdata_next;          // Read data, one cycle after strobe
    logic [7:0] buf_reg, buf_next;              // Receive buffer
    urxcs_status_t stat_reg, stat_next;         // Receive error status

    // Writes and the registered read path
    always_comb begin
        mode_next = mode_reg;
        clksel_next = clksel_reg;
        div_next = div_reg;
        rdata_next = 8'h00;
        if (reg_wr) begin
            if (reg_addr == a_mode) begin
                mode_next = urxcs_mode_t'(reg_wdata);
            end
            if (reg_addr == a_clk) begin
                clksel_next = reg_wdata[3:0];
            end
            if (reg_addr == a_div) begin
                div_next = reg_wdata;
            end
        end
        if (reg_rd) begin
            // Unmapped addresses read as zero
            unique case (1'b1)
                reg_addr == a_mode: rdata_next = mode_reg;
                reg_addr == a_buf: rdata_next = buf_reg;
                reg_addr == a_stat: rdata_next = stat_reg;
                reg_addr == a_clk: rdata_next = {4'h0, clksel_reg};
                reg_addr == a_div: rdata_next = div_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Register stage for software state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= urxcs_mode_t'(URXCS_MODE_RST);
            clksel_reg <= URXCS_CLKSEL_RST[3:0];
            div_reg <= URXCS_DIV_RST;
            rdata_reg <= 8'h00;
        end else begin
            mode_reg <= mode_next;
            clksel_reg <= clksel_next;
            div_reg <= div_next;
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // Basic clock prescaler and noise filter
    // ****************************************
    logic [URXCS_PRE_W-1:0] pre_reg, pre_next;  // Free-running prescaler
    logic [URXCS_PRE_W-1:0] pre_mask;           // Low bits that must be all ones
    logic basic_tick;                           // One-cycle basic clock enable
    logic samp_reg, samp_next;                  // Previous basic-clock sample
    logic filt_reg, filt_next;                  // Filtered line, idle high

    // Basic clock is an enable pulse at clk / 2^code; codes 11xx give no clock
    always_comb begin
        pre_mask = (URXCS_PRE_W'(1) << clksel_reg) - URXCS_PRE_W'(1);
        pre_next = mode_reg.unit_enable ? pre_reg + URXCS_PRE_W'(1) : '0;
        basic_tick = mode_reg.unit_enable && (clksel_reg <= URXCS_CLKSEL_MAX)
                     && (&(pre_reg | ~pre_mask));
        // A level is passed on only after two equal samples in a row
        samp_next = samp_reg;
        filt_next = filt_reg;
        if (basic_tick) begin
            samp_next = serial_receive_line;
            if (serial_receive_line == samp_reg) begin
                filt_next = serial_receive_line;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= '0;
            samp_reg <= 1'b1;
            filt_reg <= 1'b1;
        end else begin
            pre_reg <= pre_next;
            samp_reg <= samp_next;
            filt_reg <= filt_next;
        end
    end

    // ****************************************
    // Transmit divider and parity
    // ****************************************
    logic [7:0] txdiv_reg, txdiv_next;  // Own counter, independent of receive
    logic txtick_reg, txtick_next;      // Half-bit pulse for the transmit path
    logic txpar_reg, txpar_next;        // Parity bit the transmitter would append

    // The transmit path keeps its own divider so it never disturbs reception
    always_comb begin
        txdiv_next = txdiv_reg;
        txtick_next = 1'b0;
        if (!mode_reg.tx_enable) begin
            txdiv_next = 8'h00;
        end else if (basic_tick) begin
            if (txdiv_reg >= div_reg - 8'h01) begin
                txdiv_next = 8'h00;
                txtick_next = 1'b1;
            end else begin
                txdiv_next = txdiv_reg + 8'h01;
            end
        end
        unique case (mode_reg.parity_mode)
            URXCS_PAR_EVEN: txpar_next = ^tx_data;
            URXCS_PAR_ODD: txpar_next = ~(^tx_data);
            URXCS_PAR_ZERO: txpar_next = 1'b0;
            URXCS_PAR_NONE: txpar_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txdiv_reg <= 8'h00;
            txtick_reg <= 1'b0;
            txpar_reg <= 1'b0;
        end else begin
            txdiv_reg <= txdiv_next;
            txtick_reg <= txtick_next;
            txpar_reg <= txpar_next;
        end
    end

    // ****************************************
    // Receive divider and frame receiver
    // ****************************************
    urxcs_state_t st_reg, st_next;      // Receiver state
    logic [7:0] rxdiv_reg, rxdiv_next;  // Basic clocks within a half bit
    logic phase_reg, phase_next;        // Second half of a bit samples
    logic [2:0] bit_reg, bit_next;      // Data bit index
    logic [7:0] shift_reg, shift_next;  // Receive shift register
    logic par_reg, par_next;            // Running parity of data and parity bit
    logic full_reg, full_next;          // Buffer holds an unread frame
    logic cirq_reg, cirq_next;          // Receive-complete pulse
    logic eirq_reg, eirq_next;          // Receive-error pulse
    logic half_tick;                    // Half bit elapsed
    logic sample;                       // Mid-bit sampling point
    logic pe, fe, ov, err;              // Errors of the frame now ending
    logic rd_buf, rd_stat;              // Software reads with side effects

    assign rd_buf = reg_rd && (reg_addr == a_buf);
    assign rd_stat = reg_rd && (reg_addr == a_stat);

    // Half-bit timing: k basic clocks, so a bit takes 2k
    always_comb begin
        half_tick = basic_tick && (rxdiv_reg >= div_reg - 8'h01);
        sample = half_tick && phase_reg;
        rxdiv_next = rxdiv_reg;
        if (st_reg == URXCS_IDLE) begin
            rxdiv_next = 8'h00;
        end else if (half_tick) begin
            rxdiv_next = 8'h00;
        end else if (basic_tick) begin
            rxdiv_next = rxdiv_reg + 8'h01;
        end
    end

    // Frame sequencing, buffer handover, status and interrupts
    always_comb begin
        st_next = st_reg;
        phase_next = phase_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        par_next = par_reg;
        buf_next = buf_reg;
        // A read clears; a frame ending the same cycle sets again below
        full_next = rd_buf ? 1'b0 : full_reg;
        stat_next = rd_stat ? '0 : stat_reg;
        cirq_next = 1'b0;
        eirq_next = 1'b0;
        fe = !filt_reg;
        pe = (mode_reg.parity_mode == URXCS_PAR_EVEN && par_reg)
             || (mode_reg.parity_mode == URXCS_PAR_ODD && !par_reg);
        ov = full_reg && !rd_buf;
        err = pe || fe || ov;
        if (!mode_reg.receive_enable) begin
            // Abort at once: buffer, status and interrupts untouched
            st_next = URXCS_IDLE;
        end else if (half_tick) begin
            phase_next = !phase_reg;
        end
        if (mode_reg.receive_enable) begin
            unique case (st_reg)
                URXCS_IDLE: begin
                    phase_next = 1'b0;
                    if (!filt_reg) begin
                        st_next = URXCS_START;
                    end
                end
                URXCS_START: begin
                    // Start bit checked at its middle, half a bit in
                    if (half_tick) begin
                        phase_next = 1'b0;
                        bit_next = 3'h0;
                        par_next = 1'b0;
                        st_next = filt_reg ? URXCS_IDLE : URXCS_DATA;
                    end
                end
                URXCS_DATA: begin
                    if (sample) begin
                        shift_next = {filt_reg, shift_reg[7:1]};
                        par_next = par_reg ^ filt_reg;
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == URXCS_LAST_BIT) begin
                            st_next = (mode_reg.parity_mode == URXCS_PAR_NONE)
                                      ? URXCS_STOP : URXCS_PARITY;
                        end
                    end
                end
                URXCS_PARITY: begin
                    // Zero mode takes the position but never flags it
                    if (sample) begin
                        par_next = par_reg ^ filt_reg;
                        st_next = URXCS_STOP;
                    end
                end
                URXCS_STOP: begin
                    // Errors do not stop the frame; it always runs to here
                    if (sample) begin
                        st_next = URXCS_IDLE;
                        if (!ov) begin
                            buf_next = shift_reg;
                            full_next = 1'b1;
                        end
                        stat_next.parity_error_flag = stat_next.parity_error_flag | pe;
                        stat_next.framing_error_flag = stat_next.framing_error_flag | fe;
                        stat_next.overrun_flag = stat_next.overrun_flag | ov;
                        if (err && !mode_reg.error_irq_routing) begin
                            eirq_next = 1'b1;
                        end else begin
                            cirq_next = 1'b1;
                        end
                    end
                end
                default: st_next = URXCS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= URXCS_IDLE;
            rxdiv_reg <= 8'h00;
            phase_reg <= 1'b0;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            par_reg <= 1'b0;
            buf_reg <= URXCS_BUF_RST;
            full_reg <= 1'b0;
            stat_reg <= '0;
            cirq_reg <= 1'b0;
            eirq_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            rxdiv_reg <= rxdiv_next;
            phase_reg <= phase_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            par_reg <= par_next;
            buf_reg <= buf_next;
            full_reg <= full_next;
            stat_reg <= stat_next;
            cirq_reg <= cirq_next;
            eirq_reg <= eirq_next;
        end
    end

    // ****************************************
    // Outputs, all from flip-flops
    // ****************************************
    assign reg_rdata = rdata_reg;
    assign tx_parity_bit = txpar_reg;
    assign tx_half_tick = txtick_reg;
    assign receive_complete_irq = cirq_reg;
    assign receive_error_irq = eirq_reg;

endmodule

`default_nettype wire

/* testbench/urxcs_channel_asserts.sv */
// Port-level assertions for one receiver channel.
// Assumes one clk domain; nrst is the raw asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module urxcs_channel_asserts #(
    parameter bit CHANNEL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Transmit helpers
    input wire logic [7:0] tx_data,
    input wire logic tx_parity_bit,
    input wire logic tx_half_tick,
    // Interrupts
    input wire logic receive_complete_irq,
    input wire logic receive_error_irq
);
    import urxcs_pkg::*;
    localparam logic [31:0] MODE_A = CHANNEL ? URXCS_MODE_ADDR1 : URXCS_MODE_ADDR0;
    localparam logic [31:0] STAT_A = CHANNEL ? URXCS_STAT_ADDR1 : URXCS_STAT_ADDR0;
    logic [7:0] mode_reg; // Shadow of the mode register
    logic [7:0] mode_next;
    logic [2:0] hist_reg; // Recent interrupt pulses
    logic [2:0] hist_next;
    logic par_exp; // Parity owed for tx_data; zero mode gives 0
    logic stat_rd; // Status read strobe
    assign par_exp = mode_reg[4] & (^tx_data ^ ~mode_reg[3]);
    assign stat_rd = reg_rd && reg_addr == STAT_A;

    // ****************************************
    // Helper state
    // ****************************************
    // A frame may end near a status read, so recent pulses excuse set flags
    always_comb begin
        mode_next = mode_reg;
        hist_next = {hist_reg[1:0], receive_complete_irq | receive_error_irq};
        if (reg_wr && reg_addr == MODE_A) begin
            mode_next = reg_wdata;
        end
    end
    // Registers only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= 8'h00;
            hist_reg <= 3'h0;
        end else begin
            mode_reg <= mode_next;
            hist_reg <= hist_next;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_complete_pulse_once: assert property (receive_complete_irq |=> !receive_complete_irq)
        else $error("complete pulse longer than one cycle");
    a_error_pulse_once: assert property (receive_error_irq |=> !receive_error_irq)
        else $error("error pulse longer than one cycle");
    a_merged_no_err: assert property (mode_reg[0] && $past(mode_reg[0]) |-> !receive_error_irq)
        else $error("error interrupt while merged");
    a_rx_off_quiet: assert property (!mode_reg[5] |=> !receive_complete_irq && !receive_error_irq)
        else $error("interrupt with reception off");
    a_unit_off_quiet: assert property (!mode_reg[7] |=> !receive_complete_irq && !receive_error_irq)
        else $error("interrupt with unit off");
    a_tick_tx_off: assert property (!mode_reg[6] |=> !tx_half_tick)
        else $error("transmit tick with transmit off");
    a_tx_parity_value: assert property ($past(mode_reg[4:3]) != 2'b00 |->
        tx_parity_bit == $past(par_exp))
        else $error("transmit parity wrong");
    a_status_read_clear: assert property (stat_rd ##2 stat_rd |=>
        reg_rdata[2:0] == 3'h0 || hist_reg != 3'h0 || receive_complete_irq || receive_error_irq)
        else $error("status not cleared by read");
endmodule
`default_nettype wire

/* testbench/urxcs_line_model.sv */
// Remote serial transmitter on the receive line.
// Assumes the line idles high and bit times are whole clk cycles.
`timescale 1ns/1ps
`default_nettype none

module urxcs_line_model (
    // Clock
    input wire logic clk,
    // Serial line
    output logic line
);
    import urxcs_pkg::*;
    initial line = 1'b1;

    // Hold one level for n cycles
    task automatic drive(input logic v, input int n);
        @(posedge clk);
        line <= v;
        repeat (n - 1) @(posedge clk);
    endtask

    // Start, data LSB first, parity unless none, stop; flip and stp inject faults
    task automatic send(input logic [7:0] d, input urxcs_parity_t m, input logic flip, input logic stp, input int n);
        logic p;
        p = m[1] & (^d ^ ~m[0]);
        drive(1'b0, n);
        for (int i = 0; i < 8; i++) begin
            drive(d[i], n);
        end
        if (m != URXCS_PAR_NONE) begin
            drive(p ^ flip, n);
        end
        drive(stp, n);
        drive(1'b1, 1);
    endtask

    // One-cycle low glitch
    task automatic pulse();
        drive(1'b0, 1);
        drive(1'b1, 1);
    endtask
endmodule
`default_nettype wire

/* testbench/test_urxcs_channel.sv */
// Self-checking bench for channel 0 of the receiver.
// Assumes the line model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_urxcs_channel;
    import urxcs_pkg::*;
    logic clk, nrst, reg_wr, reg_rd, line, tx_parity_bit, tx_half_tick, irq_c, irq_e;
    logic [31:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, tx_data;
    int n_errors, n_checks;

    urxcs_channel #(.CHANNEL(1'b0)) dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_receive_line(line), .tx_data(tx_data),
        .tx_parity_bit(tx_parity_bit), .tx_half_tick(tx_half_tick), .receive_complete_irq(irq_c),
        .receive_error_irq(irq_e));
    urxcs_line_model model_u (.clk(clk), .line(line));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read strobe, then compare data in the following cycle
    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    // Send a frame and expect {error, complete} or nothing
    task automatic frame(input logic [7:0] d, input urxcs_parity_t m, input logic flip, input logic stp,
        input int n, input logic [1:0] exp);
        logic [1:0] got;
        got = 2'b00;
        @(posedge clk);
        tx_data <= d;
        fork
            model_u.send(d, m, flip, stp, n);
            for (int i = 0; i < 14 * n && got == 2'b00; i++) begin
                @(posedge clk);
                #1 got = {irq_e, irq_c};
            end
        join
        check({6'h00, got}, {6'h00, exp});
        if (exp != 2'b00 && got == 2'b00) begin
            stop_test();
        end
        repeat (40) @(posedge clk);
    endtask

    task automatic t_reset();
        rd(URXCS_MODE_ADDR0, URXCS_MODE_RST);
        rd(URXCS_DIV_ADDR0, URXCS_DIV_RST);
        rd(URXCS_BUF_ADDR0, URXCS_BUF_RST);
        rd(URXCS_CLKSEL_ADDR0, URXCS_CLKSEL_RST);
        wr(URXCS_CLKSEL_ADDR0, 8'h0B);
        rd(URXCS_CLKSEL_ADDR0, 8'h0B);
        wr(URXCS_CLKSEL_ADDR0, 8'h00);
        wr(32'hFFFFFA0F, 8'h5A);
        rd(32'hFFFFFA0F, 8'h00);
        wr(URXCS_DIV_ADDR0, 8'h08);
    endtask
    // Bad parity in even, odd and zero modes, no parity bit in none; only odd and even flag it
    task automatic t_parity();
        urxcs_parity_t m[4] = '{URXCS_PAR_EVEN, URXCS_PAR_ODD, URXCS_PAR_ZERO, URXCS_PAR_NONE};
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = 8'h3C + 8'(i);
            wr(URXCS_MODE_ADDR0, {3'b111, m[i], 3'b000});
            frame(d, m[i], 1'b1, 1'b1, 16, i < 2 ? 2'b10 : 2'b01);
            rd(URXCS_BUF_ADDR0, d);
            rd(URXCS_STAT_ADDR0, i < 2 ? 8'h04 : 8'h00);
            rd(URXCS_STAT_ADDR0, 8'h00);
        end
    endtask
    // Missing stop bit, merged interrupt
    task automatic t_framing();
        wr(URXCS_MODE_ADDR0, 8'hE1);
        frame(8'h81, URXCS_PAR_NONE, 1'b0, 1'b0, 16, 2'b01);
        rd(URXCS_BUF_ADDR0, 8'h81);
        rd(URXCS_STAT_ADDR0, 8'h02);
    endtask
    // Second frame before buffer read
    task automatic t_overrun();
        wr(URXCS_MODE_ADDR0, 8'hE0);
        frame(8'h11, URXCS_PAR_NONE, 1'b0, 1'b1, 16, 2'b01);
        frame(8'h22, URXCS_PAR_NONE, 1'b0, 1'b1, 16, 2'b10);
        rd(URXCS_BUF_ADDR0, 8'h11);
        rd(URXCS_STAT_ADDR0, 8'h01);
    endtask
    // Reception switched off mid-frame, then a whole frame while off
    task automatic t_abort();
        fork
            model_u.send(8'h5A, URXCS_PAR_NONE, 1'b0, 1'b1, 16);
            begin
                repeat (80) @(posedge clk);
                wr(URXCS_MODE_ADDR0, 8'hC0);
            end
        join
        frame(8'h66, URXCS_PAR_NONE, 1'b0, 1'b1, 16, 2'b00);
        rd(URXCS_BUF_ADDR0, 8'h11);
        rd(URXCS_STAT_ADDR0, 8'h00);
    endtask
    // Glitch inside a frame of ones, unit off, then basic clock halved
    task automatic t_clock();
        wr(URXCS_MODE_ADDR0, 8'hE0);
        model_u.drive(1'b0, 16);
        model_u.drive(1'b1, 8);
        // One-cycle low just before bit 0 is taken; a weak filter would store 8'hFE
        model_u.pulse();
        repeat (200) @(posedge clk);
        rd(URXCS_BUF_ADDR0, 8'hFF);
        wr(URXCS_MODE_ADDR0, 8'h20);
        frame(8'h99, URXCS_PAR_NONE, 1'b0, 1'b1, 16, 2'b00);
        wr(URXCS_CLKSEL_ADDR0, 8'h01);
        wr(URXCS_MODE_ADDR0, 8'hE0);
        frame(8'hC3, URXCS_PAR_NONE, 1'b0, 1'b1, 32, 2'b01);
        rd(URXCS_BUF_ADDR0, 8'hC3);
    endtask

    initial begin
        n_errors = 0;
        n_checks = 0;
        nrst = 1'b0;
        reg_addr = 32'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tx_data = 8'h00;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_parity();
        t_framing();
        t_overrun();
        t_abort();
        t_clock();
        stop_test();
    end
endmodule

bind urxcs_channel urxcs_channel_asserts #(.CHANNEL(CHANNEL)) chk_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
    .tx_parity_bit(tx_parity_bit), .tx_half_tick(tx_half_tick), .receive_complete_irq(receive_complete_irq),
    .receive_error_irq(receive_error_irq));
`default_nettype wire
